// *** shared/lpci_defines.vh ***
// constants shared by the line printer code interpreter files
`ifndef LPCI_DEFINES_VH
`define LPCI_DEFINES_VH

// register offsets (byte addresses)
`define LPCI_REG_CTRL      8'h00
`define LPCI_REG_STATUS    8'h04

// control register fields
`define LPCI_CTRL_WIDE     0
`define LPCI_CTRL_SEVEN    1
`define LPCI_CTRL_IGN8     2
`define LPCI_CTRL_CRAUTO   3
`define LPCI_CTRL_BAND_LO  4
`define LPCI_CTRL_BAND_HI  5
`define LPCI_CTRL_CTRY_LO  6
`define LPCI_CTRL_CTRY_HI  8
`define LPCI_CTRL_RESET    9'h000

// status register fields
`define LPCI_STAT_BUSY     8
`define LPCI_STAT_PEND     9
`define LPCI_STAT_FULL     10
`define LPCI_STAT_PAPER    11

// character and control codes
`define LPCI_CODE_SPACE    8'h20
`define LPCI_CODE_LF       8'h0a
`define LPCI_CODE_FF       8'h0c
`define LPCI_CODE_CR       8'h0d
`define LPCI_CODE_DEL      8'h7f

// line widths
`define LPCI_WIDTH_NARROW  8'd132
`define LPCI_WIDTH_WIDE    8'd136

// print band types
`define LPCI_BAND_NONE     2'b00
`define LPCI_BAND_64       2'b01
`define LPCI_BAND_96       2'b10
`define LPCI_BAND_48       2'b11

// decoded code kinds
`define LPCI_KIND_CHAR     2'd0
`define LPCI_KIND_LF       2'd1
`define LPCI_KIND_FF       2'd2
`define LPCI_KIND_CR       2'd3

// paper motion commands
`define LPCI_PAPER_LINE    2'd0
`define LPCI_PAPER_TOF     2'd1
`define LPCI_PAPER_CH1     2'd2
`define LPCI_PAPER_PAGE    2'd3

`endif

// *** verilog/lpci_fifo.v ***
// flip-flop fifo with valid and ready on both sides
`timescale 1ns/100ps
module lpci_fifo #(
    parameter WIDTH = 8,
    parameter DEPTH = 16,
    parameter AW    = 4
) (
    // clock and reset
    input  wire             core_clk_in,
    input  wire             sys_rst_in,
    // fill side
    input  wire             in_valid_in,
    input  wire [WIDTH-1:0] in_data_in,
    output wire             in_ready_out,
    // drain side
    output wire             out_valid_out,
    output wire [WIDTH-1:0] out_data_out,
    input  wire             out_ready_in
);
    localparam integer  DEPTH_I = DEPTH;
    localparam integer  LAST_I  = DEPTH - 1;
    localparam [AW:0]   DEPTH_C = DEPTH_I[AW:0];
    localparam [AW-1:0] LAST_C  = LAST_I[AW-1:0];

    reg [WIDTH-1:0] mem_ff [0:DEPTH-1];
    reg [AW-1:0]    wr_ptr_ff;
    reg [AW-1:0]    rd_ptr_ff;
    reg [AW:0]      count_ff;
    reg             ready_ff;
    reg             valid_ff;
    wire            push;
    wire            pop;
    wire [AW:0]     nxt_count;

    assign push      = in_valid_in & ready_ff;
    assign pop       = valid_ff & out_ready_in;
    assign nxt_count = count_ff + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};

    assign in_ready_out  = ready_ff;
    assign out_valid_out = valid_ff;
    assign out_data_out  = mem_ff[rd_ptr_ff];

    always @(posedge core_clk_in) begin
        if (push) begin
            mem_ff[wr_ptr_ff] <= in_data_in;
        end
    end

    // flags are registered so that ready has no same-cycle path from the drain side
    always @(posedge core_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            wr_ptr_ff <= {AW{1'b0}};
            rd_ptr_ff <= {AW{1'b0}};
            count_ff  <= {(AW+1){1'b0}};
            ready_ff  <= 1'b0;
            valid_ff  <= 1'b0;
        end else begin
            if (push) begin
                wr_ptr_ff <= (wr_ptr_ff == LAST_C) ? {AW{1'b0}} : wr_ptr_ff + 1'b1;
            end
            if (pop) begin
                rd_ptr_ff <= (rd_ptr_ff == LAST_C) ? {AW{1'b0}} : rd_ptr_ff + 1'b1;
            end
            count_ff <= nxt_count;
            ready_ff <= (nxt_count != DEPTH_C);
            valid_ff <= (nxt_count != {(AW+1){1'b0}});
        end
    end
endmodule // lpci_fifo

// *** verilog/lpci_charmap.v ***
// decodes a received byte into a code kind and a print glyph
`timescale 1ns/100ps
module lpci_charmap (
    // received code and settings
    input  wire [7:0]  code_in,
    input  wire        seven_bit_in,
    input  wire        ignore_bit_in,
    input  wire [1:0]  band_in,
    input  wire [2:0]  country_in,
    // decoded result
    output reg  [1:0]  kind_out,
    output reg  [10:0] glyph_out
);
    `include "lpci_defines.vh"

    reg  [7:0] eff;
    reg        defined;

    function in_band;
        input [7:0] c;
        input [1:0] band;
        begin
            case (band)
                `LPCI_BAND_48: in_band = (c == 8'h20) || (c == 8'h24) || (c == 8'h26) ||
                                         (c >= 8'h28 && c <= 8'h39) ||
                                         (c >= 8'h40 && c <= 8'h5a);
                `LPCI_BAND_64: in_band = (c >= 8'h20 && c <= 8'h5f);
                default:       in_band = (c >= 8'h20 && c <= 8'h7e);
            endcase
        end
    endfunction

    function is_national;
        input [7:0] c;
        begin
            case (c)
                8'h23, 8'h24, 8'h40, 8'h5b, 8'h5c, 8'h5d,
                8'h5e, 8'h60, 8'h7b, 8'h7c, 8'h7d, 8'h7e: is_national = 1'b1;
                default:                                  is_national = 1'b0;
            endcase
        end
    endfunction

    always @* begin
        eff = code_in;
        if (seven_bit_in && ignore_bit_in) begin
            eff = {1'b0, code_in[6:0]};
        end
        kind_out = `LPCI_KIND_CHAR;
        case (eff)
            `LPCI_CODE_LF: kind_out = `LPCI_KIND_LF;
            `LPCI_CODE_FF: kind_out = `LPCI_KIND_FF;
            `LPCI_CODE_CR: kind_out = `LPCI_KIND_CR;
            default:       kind_out = `LPCI_KIND_CHAR;
        endcase
        // the upper half is empty in both modes, so it falls to space as well
        defined = !eff[7] && (eff != `LPCI_CODE_DEL) && (eff[7:5] != 3'b000);
        if (!defined || !in_band(eff, band_in)) begin
            glyph_out = {3'b000, `LPCI_CODE_SPACE};
        end else if (is_national(eff)) begin
            glyph_out = {country_in, eff};
        end else begin
            glyph_out = {3'b000, eff};
        end
    end
endmodule // lpci_charmap

// *** verilog/lpci_interp.v ***
// line printer code interpreter: line buffer, print sequencing, paper motion
// What this block does
// - undefined or off-band codes become space, nothing printed there
// - seven-bit mode with option set treats bit eight as zero
// - characters are stored in order, printed only on a control code
// - after printing the buffer empties and next char goes to column 1
// - line feed prints from column 1 then advances one line
// - short lines are padded with spaces to the line width
// - line feed on empty buffer only advances the paper
// - form feed prints then skips to top of form or channel 1
// - forms data without channel 1 makes form feed skip to next page
// - form feed on empty buffer moves paper only, always to next such line
// - carriage return prints from column 1, motion depends on its mode
// - a fixed set of codes maps to country glyphs of the selected country
// - no-feed carriage return mode never moves paper; empty does nothing
// - automatic spacing mode handles carriage return as a line feed
// - other control-area codes are treated as space
`timescale 1ns/100ps
module lpci_interp #(
    parameter LINE_MAX   = 136,
    parameter FIFO_DEPTH = 16,
    parameter FIFO_AW    = 4
) (
    // clock and reset
    input  wire        core_clk_in,
    input  wire        sys_rst_in,
    // host byte stream
    input  wire [7:0]  host_data_in,
    input  wire        host_strobe_in,
    output wire        host_ready_out,
    // forms control state
    input  wire        fcb_loaded_in,
    input  wire        fcb_has_ch1_in,
    // print engine column stream
    output reg         print_valid_out,
    output reg  [10:0] print_glyph_out,
    output reg  [7:0]  print_col_out,
    output reg         print_last_out,
    input  wire        print_ready_in,
    // paper motion
    output reg         paper_req_out,
    output reg  [1:0]  paper_cmd_out,
    input  wire        paper_ack_in,
    // register port
    input  wire [7:0]  reg_addr_in,
    input  wire [31:0] reg_wdata_in,
    input  wire        reg_wr_in,
    input  wire        reg_rd_in,
    output reg  [31:0] reg_rdata_out
);
    `include "lpci_defines.vh"

    localparam [3:0] ST_IDLE  = 4'b0001;
    localparam [3:0] ST_PRINT = 4'b0010;
    localparam [3:0] ST_FEED  = 4'b0100;
    localparam [3:0] ST_WAIT  = 4'b1000;

    // state
    reg  [3:0]  state_ff;
    reg  [3:0]  nxt_state;
    reg  [7:0]  count_ff;
    reg  [7:0]  nxt_count;
    reg  [7:0]  col_ff;
    reg  [7:0]  nxt_col;
    reg         feed_ff;
    reg         nxt_feed;
    reg  [1:0]  cmd_ff;
    reg  [1:0]  nxt_cmd;
    reg  [8:0]  ctrl_ff;
    reg  [10:0] line_char_buffer [0:LINE_MAX-1];
    // outputs
    reg         nxt_pvalid;
    reg  [10:0] nxt_pglyph;
    reg  [7:0]  nxt_pcol;
    reg         nxt_plast;
    reg         nxt_preq;
    reg  [1:0]  nxt_pcmd;
    reg         buf_wr;
    reg         pop;
    // decode
    wire        fifo_valid;
    wire [7:0]  fifo_data;
    wire [1:0]  kind;
    wire [10:0] glyph;
    wire [7:0]  width;
    wire        cr_auto;
    wire        line_full;

    assign width     = ctrl_ff[`LPCI_CTRL_WIDE] ? `LPCI_WIDTH_WIDE : `LPCI_WIDTH_NARROW;
    assign cr_auto   = ctrl_ff[`LPCI_CTRL_CRAUTO];
    assign line_full = (count_ff >= width);

    lpci_fifo #(
        .WIDTH (8),
        .DEPTH (FIFO_DEPTH),
        .AW    (FIFO_AW)
    ) u_fifo (
        .core_clk_in   (core_clk_in),
        .sys_rst_in    (sys_rst_in),
        .in_valid_in   (host_strobe_in),
        .in_data_in    (host_data_in),
        .in_ready_out  (host_ready_out),
        .out_valid_out (fifo_valid),
        .out_data_out  (fifo_data),
        .out_ready_in  (pop)
    );

    lpci_charmap u_map (
        .code_in       (fifo_data),
        .seven_bit_in  (ctrl_ff[`LPCI_CTRL_SEVEN]),
        .ignore_bit_in (ctrl_ff[`LPCI_CTRL_IGN8]),
        .band_in       (ctrl_ff[`LPCI_CTRL_BAND_HI:`LPCI_CTRL_BAND_LO]),
        .country_in    (ctrl_ff[`LPCI_CTRL_CTRY_HI:`LPCI_CTRL_CTRY_LO]),
        .kind_out      (kind),
        .glyph_out     (glyph)
    );

    // form feed target depends on what the forms buffer holds
    function [1:0] ff_target;
        input loaded;
        input has_ch1;
        begin
            if (!loaded) begin
                ff_target = `LPCI_PAPER_TOF;
            end else if (has_ch1) begin
                ff_target = `LPCI_PAPER_CH1;
            end else begin
                ff_target = `LPCI_PAPER_PAGE;
            end
        end
    endfunction

    always @* begin
        nxt_state  = state_ff;
        nxt_count  = count_ff;
        nxt_col    = col_ff;
        nxt_feed   = feed_ff;
        nxt_cmd    = cmd_ff;
        nxt_pvalid = print_valid_out;
        nxt_pglyph = print_glyph_out;
        nxt_pcol   = print_col_out;
        nxt_plast  = print_last_out;
        nxt_preq   = paper_req_out;
        nxt_pcmd   = paper_cmd_out;
        buf_wr     = 1'b0;
        pop        = 1'b0;
        case (state_ff)
            ST_IDLE: begin
                if (fifo_valid) begin
                    pop = 1'b1;
                    nxt_col = 8'd0;
                    case (kind)
                        `LPCI_KIND_LF: begin
                            nxt_feed = 1'b1;
                            nxt_cmd  = `LPCI_PAPER_LINE;
                        end
                        `LPCI_KIND_FF: begin
                            // the paper unit always skips forward to the next target line
                            nxt_feed = 1'b1;
                            nxt_cmd  = ff_target(fcb_loaded_in, fcb_has_ch1_in);
                        end
                        `LPCI_KIND_CR: begin
                            nxt_feed = cr_auto;
                            nxt_cmd  = `LPCI_PAPER_LINE;
                        end
                        default: begin
                            nxt_feed = 1'b0;
                            if (!line_full) begin
                                buf_wr    = 1'b1;
                                nxt_count = count_ff + 8'd1;
                            end
                        end
                    endcase
                    if (kind != `LPCI_KIND_CHAR) begin
                        if (count_ff != 8'd0) begin
                            nxt_state = ST_PRINT;
                        end else if (nxt_feed) begin
                            nxt_state = ST_FEED;
                        end
                    end
                end
            end
            ST_PRINT: begin
                if (!print_valid_out || print_ready_in) begin
                    if (col_ff < width) begin
                        nxt_pvalid = 1'b1;
                        nxt_pcol   = col_ff;
                        nxt_plast  = (col_ff == width - 8'd1);
                        nxt_col    = col_ff + 8'd1;
                        if (col_ff < count_ff) begin
                            nxt_pglyph = line_char_buffer[col_ff];
                        end else begin
                            nxt_pglyph = {3'b000, `LPCI_CODE_SPACE};
                        end
                    end else begin
                        // last column taken: empty the line before any motion
                        nxt_pvalid = 1'b0;
                        nxt_plast  = 1'b0;
                        nxt_count  = 8'd0;
                        nxt_state  = feed_ff ? ST_FEED : ST_IDLE;
                    end
                end
            end
            ST_FEED: begin
                nxt_preq  = 1'b1;
                nxt_pcmd  = cmd_ff;
                nxt_state = ST_WAIT;
            end
            ST_WAIT: begin
                if (paper_ack_in) begin
                    nxt_preq  = 1'b0;
                    nxt_feed  = 1'b0;
                    nxt_state = ST_IDLE;
                end
            end
            default: begin
                nxt_state = ST_IDLE;
            end
        endcase
    end

    // line storage has no reset; the count alone says what is valid
    always @(posedge core_clk_in) begin
        if (buf_wr) begin
            line_char_buffer[count_ff] <= glyph;
        end
    end

    always @(posedge core_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            state_ff        <= ST_IDLE;
            count_ff        <= 8'd0;
            col_ff          <= 8'd0;
            feed_ff         <= 1'b0;
            cmd_ff          <= `LPCI_PAPER_LINE;
            print_valid_out <= 1'b0;
            print_glyph_out <= 11'h000;
            print_col_out   <= 8'd0;
            print_last_out  <= 1'b0;
            paper_req_out   <= 1'b0;
            paper_cmd_out   <= `LPCI_PAPER_LINE;
        end else begin
            state_ff        <= nxt_state;
            count_ff        <= nxt_count;
            col_ff          <= nxt_col;
            feed_ff         <= nxt_feed;
            cmd_ff          <= nxt_cmd;
            print_valid_out <= nxt_pvalid;
            print_glyph_out <= nxt_pglyph;
            print_col_out   <= nxt_pcol;
            print_last_out  <= nxt_plast;
            paper_req_out   <= nxt_preq;
            paper_cmd_out   <= nxt_pcmd;
        end
    end

    // register port; mid-line changes apply to codes decoded after them, but the width applies to the whole line
    always @(posedge core_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            ctrl_ff       <= `LPCI_CTRL_RESET;
            reg_rdata_out <= 32'h0000_0000;
        end else begin
            if (reg_wr_in && (reg_addr_in == `LPCI_REG_CTRL)) begin
                ctrl_ff <= reg_wdata_in[8:0];
            end
            if (reg_rd_in) begin
                case (reg_addr_in)
                    `LPCI_REG_CTRL: begin
                        reg_rdata_out <= {23'h0, ctrl_ff};
                    end
                    `LPCI_REG_STATUS: begin
                        reg_rdata_out <= {20'h00000, paper_req_out, line_full,
                                          fifo_valid, (state_ff != ST_IDLE), count_ff};
                    end
                    default: begin
                        reg_rdata_out <= 32'h0000_0000;
                    end
                endcase
            end else begin
                reg_rdata_out <= 32'h0000_0000;
            end
        end
    end
endmodule // lpci_interp

// *** tb/lpci_interp_checker.sv ***
// port checker for the line printer code interpreter
`timescale 1ns/100ps
module lpci_interp_checker (
    // clock and reset
    input wire        core_clk_in,
    input wire        sys_rst_in,
    // print engine side
    input wire        print_valid_out,
    input wire [10:0] print_glyph_out,
    input wire [7:0]  print_col_out,
    input wire        print_last_out,
    input wire        print_ready_in,
    // paper side
    input wire        paper_req_out,
    input wire [1:0]  paper_cmd_out,
    input wire        paper_ack_in
);
    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (sys_rst_in);

    a_valid_hold: assert property (print_valid_out && !print_ready_in |=> print_valid_out
        && $stable(print_glyph_out) && $stable(print_col_out)) else $error("column dropped");
    a_col_start: assert property ($rose(print_valid_out) |-> print_col_out == 8'h00)
        else $error("line not started at column one");
    a_col_step: assert property (print_valid_out && print_ready_in && !print_last_out
        |=> print_valid_out && print_col_out == $past(print_col_out) + 8'h01)
        else $error("column skipped");
    a_last_col: assert property (print_valid_out && print_last_out
        |-> print_col_out == 8'h83 || print_col_out == 8'h87) else $error("bad last column");
    a_last_drop: assert property (print_valid_out && print_ready_in && print_last_out
        |=> !print_valid_out) else $error("print ran past last column");
    a_motion_after: assert property (print_valid_out |-> !paper_req_out)
        else $error("paper moved during print");
    a_req_hold: assert property (paper_req_out && !paper_ack_in
        |=> paper_req_out && $stable(paper_cmd_out)) else $error("motion request lost");
    a_req_drop: assert property (paper_req_out && paper_ack_in |=> !paper_req_out)
        else $error("motion request repeated");
    a_country_set: assert property (print_valid_out && print_glyph_out[10:8] != 3'h0
        |-> print_glyph_out[7:0] inside {8'h23, 8'h24, 8'h40, [8'h5b:8'h5e], 8'h60,
        [8'h7b:8'h7e]}) else $error("country bits on plain code");
endmodule // lpci_interp_checker

bind lpci_interp lpci_interp_checker lpci_interp_checker_i (
    .core_clk_in(core_clk_in), .sys_rst_in(sys_rst_in), .print_valid_out(print_valid_out),
    .print_glyph_out(print_glyph_out), .print_col_out(print_col_out),
    .print_last_out(print_last_out), .print_ready_in(print_ready_in),
    .paper_req_out(paper_req_out), .paper_cmd_out(paper_cmd_out), .paper_ack_in(paper_ack_in));

// *** tb/lpci_engine_model.sv ***
// print engine and paper unit model facing the interpreter
`timescale 1ns/100ps
module lpci_engine_model (
    // clock and reset
    input  wire        core_clk_in,
    input  wire        sys_rst_in,
    // 0 fast, 1 every other cycle, 2 hold off
    input  wire [1:0]  mode_in,
    // column stream
    input  wire        print_valid_in,
    input  wire [10:0] print_glyph_in,
    input  wire [7:0]  print_col_in,
    output reg         print_ready_out,
    // paper motion
    input  wire        paper_req_in,
    input  wire [1:0]  paper_cmd_in,
    output reg         paper_ack_out
);
    reg [10:0] glyph_ff [0:255];
    integer    n_cols;
    integer    n_feed;
    reg [1:0]  cmd_ff;
    always @(posedge core_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            print_ready_out <= 1'b0;
            paper_ack_out <= 1'b0;
            n_cols <= 0;
            n_feed <= 0;
            cmd_ff <= 2'h0;
        end else begin
            print_ready_out <= (mode_in == 2'h0) | ((mode_in == 2'h1) & ~print_ready_out);
            if (print_valid_in && print_ready_out) begin
                glyph_ff[print_col_in] <= print_glyph_in;
                n_cols <= n_cols + 1;
            end
            // one-cycle ack, so each motion is counted once
            paper_ack_out <= paper_req_in & ~paper_ack_out;
            if (paper_req_in && !paper_ack_out) begin
                n_feed <= n_feed + 1;
                cmd_ff <= paper_cmd_in;
            end
        end
    end
endmodule // lpci_engine_model

// *** tb/lpci_interp_tb.sv ***
// self-checking bench for the line printer code interpreter
`timescale 1ns/100ps
`define chk(a, b) begin tests_run = tests_run + 1; if ((a) !== (b)) begin \
    error_cnt = error_cnt + 1; $display("BAD t=%0t got %h exp %h", $time, a, b); end end
module lpci_interp_tb;
    reg         clk = 1'b0;
    reg         rst = 1'b1;
    reg         strobe = 1'b0;
    reg         fcb_ld = 1'b0;
    reg         fcb_c1 = 1'b0;
    reg         reg_wr = 1'b0;
    reg         reg_rd = 1'b0;
    reg [7:0]   hdata = 8'h00;
    reg [7:0]   addr = 8'h00;
    reg [31:0]  wdata = 32'h0;
    reg [1:0]   mode = 2'h0;
    reg [31:0]  d;
    wire        h_rdy, p_val, p_last, p_rdy, q_req, q_ack;
    wire [10:0] p_gly;
    wire [7:0]  p_col;
    wire [1:0]  q_cmd;
    wire [31:0] rdata;
    integer     error_cnt = 0;
    integer     tests_run = 0;
    integer     cyc = 0;
    integer     c0, f0, i, n;

    lpci_interp lpci_interp_i (.core_clk_in(clk), .sys_rst_in(rst), .host_data_in(hdata),
        .host_strobe_in(strobe), .host_ready_out(h_rdy), .fcb_loaded_in(fcb_ld),
        .fcb_has_ch1_in(fcb_c1), .print_valid_out(p_val), .print_glyph_out(p_gly),
        .print_col_out(p_col), .print_last_out(p_last), .print_ready_in(p_rdy),
        .paper_req_out(q_req), .paper_cmd_out(q_cmd), .paper_ack_in(q_ack),
        .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_wr_in(reg_wr), .reg_rd_in(reg_rd),
        .reg_rdata_out(rdata));
    lpci_engine_model lpci_engine_model_i (.core_clk_in(clk), .sys_rst_in(rst),
        .mode_in(mode), .print_valid_in(p_val), .print_glyph_in(p_gly), .print_col_in(p_col),
        .print_ready_out(p_rdy), .paper_req_in(q_req), .paper_cmd_in(q_cmd),
        .paper_ack_out(q_ack));

    always #2.5 clk = ~clk;
    // generous ceiling: about a dozen lines of 140 columns plus polling
    always @(posedge clk) begin
        cyc = cyc + 1;
        if (cyc == 60000) begin
            error_cnt = error_cnt + 1;
            finish_test;
        end
    end

    task finish_test;
        begin
            $display("checks %0d mismatches %0d", tests_run, error_cnt);
            if (error_cnt == 0 && tests_run > 0) begin
                $display("DONE - PASS");
            end else begin
                $display("DONE - FAIL");
            end
            $finish;
        end
    endtask
    task wr(input [7:0] a, input [31:0] v);
        begin
            addr <= a; wdata <= v; reg_wr <= 1'b1;
            @(posedge clk);
            reg_wr <= 1'b0;
        end
    endtask
    task rd(input [7:0] a, output [31:0] v);
        begin
            addr <= a; reg_rd <= 1'b1;
            @(posedge clk);
            reg_rd <= 1'b0;
            @(posedge clk);
            v = rdata;
        end
    endtask
    // strobe stays up between bytes so a batch streams back to back
    task send(input [7:0] b);
        begin
            hdata <= b; strobe <= 1'b1;
            @(posedge clk);
            while (h_rdy !== 1'b1) @(posedge clk);
        end
    endtask
    // idle means no fifo byte, not busy, line not full, no motion pending
    task settle;
        integer k;
        begin
            repeat (3) @(posedge clk);
            d = 32'hfff;
            for (k = 0; k < 2000 && d[11:8] !== 4'h0; k = k + 1) rd(8'h04, d);
            if (d[11:8] !== 4'h0) begin error_cnt = error_cnt + 1; finish_test; end
        end
    endtask
    task prt(input [7:0] ctl);
        begin
            c0 = lpci_engine_model_i.n_cols; f0 = lpci_engine_model_i.n_feed;
            send(ctl); strobe <= 1'b0; settle;
        end
    endtask
    task cg(input integer k, input [10:0] e);
        `chk(lpci_engine_model_i.glyph_ff[k], e)
    endtask
    task cl(input integer nc, input integer nf, input [1:0] cmd);
        begin
            `chk(lpci_engine_model_i.n_cols - c0, nc)
            `chk(lpci_engine_model_i.n_feed - f0, nf)
            if (nf != 0) `chk(lpci_engine_model_i.cmd_ff, cmd)
        end
    endtask

    initial begin
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        rd(8'h00, d); `chk(d, 32'h0)
        wr(8'h00, 32'h1ff); rd(8'h00, d); `chk(d, 32'h1ff)
        wr(8'h08, 32'h5); rd(8'h08, d); `chk(d, 32'h0)
        wr(8'h00, 32'h080); $display("end registers");
        send(8'h41); send(8'h23); send(8'h01); send(8'h7f); send(8'h80); prt(8'h0a);
        cl(132, 1, 2'h0); cg(0, 11'h041); cg(1, 11'h223);
        for (i = 2; i < 132; i = i + 1) cg(i, 11'h020);
        prt(8'h0a); cl(0, 1, 2'h0);
        wr(8'h00, 32'h1); send(8'h5a); prt(8'h0c); cl(136, 1, 2'h1);
        cg(135, 11'h020);
        fcb_ld <= 1'b1; fcb_c1 <= 1'b1; prt(8'h0c); cl(0, 1, 2'h2);
        fcb_c1 <= 1'b0; prt(8'h0c); cl(0, 1, 2'h3); $display("end feeds");
        wr(8'h00, 32'h016); send(8'hc1); send(8'h61); prt(8'h0a);
        cg(0, 11'h041); cg(1, 11'h020);
        wr(8'h00, 32'h032); send(8'hc1); send(8'h26); send(8'h25); prt(8'h0a);
        cg(0, 11'h020); cg(1, 11'h026); cg(2, 11'h020);
        wr(8'h00, 32'h0); send(8'h42); prt(8'h0d); cl(132, 0, 2'h0);
        prt(8'h0d); cl(0, 0, 2'h0);
        wr(8'h00, 32'h8); prt(8'h0d); cl(0, 1, 2'h0);
        send(8'h42); prt(8'h0d); cl(132, 1, 2'h0); $display("end returns");
        mode <= 2'h1;
        for (i = 0; i < 140; i = i + 1) send(i == 131 ? 8'h46 : (i > 131 ? 8'h47 : 8'h45));
        strobe <= 1'b0; repeat (4) @(posedge clk);
        rd(8'h04, d); `chk(d[10:0], 11'h484)
        prt(8'h0a); cl(132, 1, 2'h0); cg(131, 11'h046);
        send(8'h43); prt(8'h0a); cg(0, 11'h043); cg(1, 11'h020);
        mode <= 2'h2; $display("end overflow");
        send(8'h41); send(8'h0a); strobe <= 1'b0;
        repeat (4) @(posedge clk);
        n = 0; hdata <= 8'h44; strobe <= 1'b1;
        for (i = 0; i < 20; i = i + 1) begin
            @(posedge clk);
            if (h_rdy === 1'b1) n = n + 1;
        end
        strobe <= 1'b0; `chk(n, 16)
        rd(8'h04, d); `chk(d[9], 1'b1)
        mode <= 2'h0; settle; prt(8'h0a); cl(132, 1, 2'h0);
        cg(15, 11'h044); cg(16, 11'h020); $display("end buffering");
        finish_test;
    end
endmodule // lpci_interp_tb
